// [rtl/prm_pkg.sv]
// package for the peripheral pin remap block: register map, route codes, carriers
package prm_pkg;

  localparam int unsigned NUM_PINS     = 32;
  localparam int unsigned NUM_INPUTS   = 8;
  localparam int unsigned GRP_PINS     = 8;
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned SEL_W        = 4;

  // byte addresses
  localparam logic [11:0] OUT_ROUTE_BASE = 12'h000;
  localparam logic [11:0] IN_ROUTE_BASE  = 12'h080;
  localparam logic [11:0] LOCK_ADDR      = 12'h0a0;
  localparam logic [11:0] OWN_STAT_ADDR  = 12'h0a4;

  // lock register fields
  localparam int unsigned LOCK_SET_BIT   = 0;
  localparam int unsigned KEY_LSB        = 16;
  localparam logic [15:0] UNLOCK_KEY     = 16'h5a3c;

  localparam logic [3:0]  ROUTE_RESET    = 4'h0;
  localparam logic        LOCK_RESET     = 1'b0;

  // output route codes per pin group
  localparam logic [3:0]  CODE_NC        = 4'h0;
  localparam logic [3:0]  G0_UART_A_TX   = 4'h1;
  localparam logic [3:0]  G0_UART_B_RTS  = 4'h2;
  localparam logic [3:0]  G0_SPI_A_SS    = 4'h3;
  localparam logic [3:0]  G0_CMP_B_OUT   = 4'h7;
  localparam logic [3:0]  G1_SPI_A_SDO   = 4'h3;
  localparam logic [3:0]  G1_SPI_B_SDO   = 4'h4;
  localparam logic [3:0]  G1_OC_B        = 4'h5;
  localparam logic [3:0]  G2_SPI_A_SDO   = 4'h3;
  localparam logic [3:0]  G2_SPI_B_SDO   = 4'h4;
  localparam logic [3:0]  G2_OC_D        = 4'h5;
  localparam logic [3:0]  G3_SPI_B_SS    = 4'h4;
  localparam logic [3:0]  G3_OC_C        = 4'h5;

  // input route codes above this pick no pin
  localparam logic [3:0]  IN_CODE_MAX    = 4'h7;

  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  typedef struct packed {
    logic uart_a_transmit;
    logic uart_b_request_to_send;
    logic spi_a_slave_select;
    logic comparator_b_output;
    logic spi_a_data_out;
    logic spi_b_data_out;
    logic compare_out_ch_b;
    logic compare_out_ch_c;
    logic compare_out_ch_d;
    logic spi_b_slave_select;
  } prm_pout_s;

  // element order runs from input route register index 7 down to 0
  typedef struct packed {
    logic timer_c_clock;
    logic capture_ch_b;
    logic change_notify_b;
    logic spi_b_slave_select_in;
    logic spi_b_data_in;
    logic spi_a_data_in;
    logic uart_b_receive;
    logic uart_a_receive;
  } prm_pin_s;

endpackage

// [rtl/prm_remap.sv]
// peripheral pin remap block with an axi4-lite register slave
`timescale 1ns/1ps

// Behaviour
// - routing acts only on 32 remappable pins, digital peripherals only
// - input routes and output routes live in separate register sets
// - input field value selects remappable pin of that number for the peripheral; here input k takes pin (k mod 4)*8 + value for values 0-7
// - per-pin 4-bit output field; code 0000 leaves pin unconnected
// - group 0: 0001 uart a transmit, 0010 uart b rts, 0011 spi a select
// - group 0: 0111 comparator b output; 0100-0110 and 1000-1111 reserved
// - group 1: 0011/0100 spi a/b data, 0101 compare channel b
// - group 2: 0011/0100 spi a/b data, 0101 compare channel d
// - group 3: 0100 spi b select, 0101 compare channel c
// - remappable peripheral reaches no pin until software assigns one; here only outputs: inputs reset to code 0 and read pin (k mod 4)*8
// - fixed peripheral drives its default pin when active and unconflicted
// - active remapped peripheral owns pin over every other digital function
// - analog function on a pin always beats a remapped peripheral
// - two-wire serial bus is never offered through the routing
// - modules with analog inputs are never routable
// - hardware protects the mapping against spurious writes once set
module prm_remap
  import prm_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [DATA_W-1:0]   wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [DATA_W-1:0]        rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire prm_pout_s           periph_out,
  input  wire prm_pout_s           periph_act,
  output prm_pin_s                 periph_in,
  input  wire logic [NUM_PINS-1:0] pin_in,
  input  wire logic [NUM_PINS-1:0] analog_en,
  input  wire logic [NUM_PINS-1:0] dflt_out,
  input  wire logic [NUM_PINS-1:0] dflt_oe,
  output logic [NUM_PINS-1:0]      pin_out,
  output logic [NUM_PINS-1:0]      pin_oe,
  output logic [NUM_PINS-1:0]      remap_own
);

  // register state
  logic [NUM_PINS-1:0][SEL_W-1:0]   out_route_r, out_route_nxt;
  logic [NUM_INPUTS-1:0][SEL_W-1:0] in_route_r, in_route_nxt;
  logic                             lock_r, lock_nxt;

  // bus state
  logic                aw_have_r, aw_have_nxt;
  logic [ADDR_W-1:0]   aw_addr_r, aw_addr_nxt;
  logic                w_have_r, w_have_nxt;
  logic [DATA_W-1:0]   w_data_r, w_data_nxt;
  logic [3:0]          w_strb_r, w_strb_nxt;
  logic                bvalid_r, bvalid_nxt;
  logic [1:0]          bresp_r, bresp_nxt;
  logic                rvalid_r, rvalid_nxt;
  logic [DATA_W-1:0]   rdata_r, rdata_nxt;
  logic [1:0]          rresp_r, rresp_nxt;

  // pin state
  logic [NUM_PINS-1:0] pin_out_r, pin_out_nxt;
  logic [NUM_PINS-1:0] pin_oe_r, pin_oe_nxt;
  logic [NUM_PINS-1:0] own_r, own_nxt;
  logic [NUM_INPUTS-1:0] pin_in_vec_r, pin_in_vec_nxt;

  logic                aw_now, w_now, do_write;
  logic [ADDR_W-1:0]   wr_addr;
  logic [DATA_W-1:0]   wr_data;
  logic [3:0]          wr_strb;
  logic                wr_is_out, wr_is_in, wr_is_route;

  function automatic logic is_out_addr(input logic [ADDR_W-1:0] a);
    return a[11:7] == OUT_ROUTE_BASE[11:7];
  endfunction

  function automatic logic is_in_addr(input logic [ADDR_W-1:0] a);
    return a[11:5] == IN_ROUTE_BASE[11:5];
  endfunction

  // returns {owned, data}; only these peripherals exist in the table
  function automatic logic [1:0] route_out(input logic [1:0]  grp,
                                           input logic [3:0]  code,
                                           input prm_pout_s   d,
                                           input prm_pout_s   a);
    logic [1:0] r;
    r = 2'b00;
    case (grp)
      2'd0: begin
        case (code)
          G0_UART_A_TX:  r = {a.uart_a_transmit, d.uart_a_transmit};
          G0_UART_B_RTS: r = {a.uart_b_request_to_send, d.uart_b_request_to_send};
          G0_SPI_A_SS:   r = {a.spi_a_slave_select, d.spi_a_slave_select};
          G0_CMP_B_OUT:  r = {a.comparator_b_output, d.comparator_b_output};
          default:       r = 2'b00;
        endcase
      end
      2'd1: begin
        case (code)
          G1_SPI_A_SDO:  r = {a.spi_a_data_out, d.spi_a_data_out};
          G1_SPI_B_SDO:  r = {a.spi_b_data_out, d.spi_b_data_out};
          G1_OC_B:       r = {a.compare_out_ch_b, d.compare_out_ch_b};
          default:       r = 2'b00;
        endcase
      end
      2'd2: begin
        case (code)
          G2_SPI_A_SDO:  r = {a.spi_a_data_out, d.spi_a_data_out};
          G2_SPI_B_SDO:  r = {a.spi_b_data_out, d.spi_b_data_out};
          G2_OC_D:       r = {a.compare_out_ch_d, d.compare_out_ch_d};
          default:       r = 2'b00;
        endcase
      end
      default: begin
        case (code)
          G3_SPI_B_SS:   r = {a.spi_b_slave_select, d.spi_b_slave_select};
          G3_OC_C:       r = {a.compare_out_ch_c, d.compare_out_ch_c};
          default:       r = 2'b00;
        endcase
      end
    endcase
    return {r[1], r[1] & r[0]};
  endfunction

  // write channel: address and data accepted in either order
  assign awready = !aw_have_r && !bvalid_r;
  assign wready  = !w_have_r && !bvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = !rvalid_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  assign aw_now      = aw_have_r || (awvalid && awready);
  assign w_now       = w_have_r || (wvalid && wready);
  assign do_write    = aw_now && w_now && !bvalid_r;
  assign wr_addr     = aw_have_r ? aw_addr_r : awaddr;
  assign wr_data     = w_have_r ? w_data_r : wdata;
  assign wr_strb     = w_have_r ? w_strb_r : wstrb;
  assign wr_is_out   = is_out_addr(wr_addr);
  assign wr_is_in    = is_in_addr(wr_addr);
  assign wr_is_route = wr_is_out || wr_is_in;

  always_comb begin
    aw_have_nxt   = aw_have_r;
    aw_addr_nxt   = aw_addr_r;
    w_have_nxt    = w_have_r;
    w_data_nxt    = w_data_r;
    w_strb_nxt    = w_strb_r;
    bvalid_nxt    = bvalid_r;
    bresp_nxt     = bresp_r;
    out_route_nxt = out_route_r;
    in_route_nxt  = in_route_r;
    lock_nxt      = lock_r;
    if (awvalid && awready) begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = awaddr;
    end
    if (wvalid && wready) begin
      w_have_nxt = 1'b1;
      w_data_nxt = wdata;
      w_strb_nxt = wstrb;
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_write) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_OKAY;
      if (wr_is_route) begin
        if (lock_r) begin
          bresp_nxt = RESP_SLVERR;
        end else if (wr_strb[0] && wr_is_out) begin
          out_route_nxt[wr_addr[6:2]] = wr_data[SEL_W-1:0];
        end else if (wr_strb[0]) begin
          in_route_nxt[wr_addr[4:2]] = wr_data[SEL_W-1:0];
        end
      end else if (wr_addr[11:2] == LOCK_ADDR[11:2]) begin
        // set freely, clear only with the key in the upper half
        if (wr_strb[0] && wr_data[LOCK_SET_BIT]) begin
          lock_nxt = 1'b1;
        end else if (wr_strb[0] && wr_data[DATA_W-1:KEY_LSB] == UNLOCK_KEY) begin
          lock_nxt = 1'b0;
        end
      end else begin
        bresp_nxt = RESP_SLVERR;
      end
    end
  end

  // read channel
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      rdata_nxt  = '0;
      if (is_out_addr(araddr)) begin
        rdata_nxt[SEL_W-1:0] = out_route_r[araddr[6:2]];
      end else if (is_in_addr(araddr)) begin
        rdata_nxt[SEL_W-1:0] = in_route_r[araddr[4:2]];
      end else if (araddr[11:2] == LOCK_ADDR[11:2]) begin
        rdata_nxt[LOCK_SET_BIT] = lock_r;
      end else if (araddr[11:2] == OWN_STAT_ADDR[11:2]) begin
        rdata_nxt = own_r;
      end else begin
        rresp_nxt = RESP_SLVERR;
      end
    end
  end

  // output side: one mux per remappable pin
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    logic [1:0] sel;
    assign sel = route_out(2'(p / GRP_PINS), out_route_r[p], periph_out, periph_act);
    always_comb begin
      if (analog_en[p]) begin
        own_nxt[p]     = 1'b0;
        pin_oe_nxt[p]  = 1'b0;
        pin_out_nxt[p] = 1'b0;
      end else if (sel[1]) begin
        own_nxt[p]     = 1'b1;
        pin_oe_nxt[p]  = 1'b1;
        pin_out_nxt[p] = sel[0];
      end else begin
        own_nxt[p]     = 1'b0;
        pin_oe_nxt[p]  = dflt_oe[p];
        pin_out_nxt[p] = dflt_out[p];
      end
    end
  end

  // input side: input k picks pin {k mod 4, code} while code is in range
  for (genvar k = 0; k < NUM_INPUTS; k++) begin : g_in
    logic [4:0] idx;
    assign idx = {2'(k % 4), in_route_r[k][2:0]};
    always_comb begin
      if (in_route_r[k] <= IN_CODE_MAX) begin
        pin_in_vec_nxt[k] = pin_in[idx] && !analog_en[idx];
      end else begin
        pin_in_vec_nxt[k] = 1'b0;
      end
    end
  end

  assign periph_in = prm_pin_s'(pin_in_vec_r);
  assign pin_out   = pin_out_r;
  assign pin_oe    = pin_oe_r;
  assign remap_own = own_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r    <= 1'b0;
      aw_addr_r    <= '0;
      w_have_r     <= 1'b0;
      w_data_r     <= '0;
      w_strb_r     <= '0;
      bvalid_r     <= 1'b0;
      bresp_r      <= RESP_OKAY;
      rvalid_r     <= 1'b0;
      rdata_r      <= '0;
      rresp_r      <= RESP_OKAY;
      out_route_r  <= {NUM_PINS{ROUTE_RESET}};
      in_route_r   <= {NUM_INPUTS{ROUTE_RESET}};
      lock_r       <= LOCK_RESET;
      pin_out_r    <= '0;
      pin_oe_r     <= '0;
      own_r        <= '0;
      pin_in_vec_r <= '0;
    end else begin
      aw_have_r    <= aw_have_nxt;
      aw_addr_r    <= aw_addr_nxt;
      w_have_r     <= w_have_nxt;
      w_data_r     <= w_data_nxt;
      w_strb_r     <= w_strb_nxt;
      bvalid_r     <= bvalid_nxt;
      bresp_r      <= bresp_nxt;
      rvalid_r     <= rvalid_nxt;
      rdata_r      <= rdata_nxt;
      rresp_r      <= rresp_nxt;
      out_route_r  <= out_route_nxt;
      in_route_r   <= in_route_nxt;
      lock_r       <= lock_nxt;
      pin_out_r    <= pin_out_nxt;
      pin_oe_r     <= pin_oe_nxt;
      own_r        <= own_nxt;
      pin_in_vec_r <= pin_in_vec_nxt;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_lock_set;
    do_write && !wr_is_route && wr_addr[11:2] == LOCK_ADDR[11:2] && wr_strb[0]
      && wr_data[LOCK_SET_BIT];
  endsequence

  sequence s_route_wr;
    do_write && wr_is_route;
  endsequence

  lock_holds_map_a: assert property (
    lock_r ##0 s_route_wr |=> $stable(out_route_r) && $stable(in_route_r)
      && bvalid && bresp == RESP_SLVERR)
    else $error("route register changed while locked");

  lock_set_a: assert property (
    s_lock_set |=> lock_r)
    else $error("lock bit not set by its write");

  lock_sticky_a: assert property (
    lock_r && !(do_write && wr_data[DATA_W-1:KEY_LSB] == UNLOCK_KEY) |=> lock_r)
    else $error("lock dropped without the key");

  reset_unrouted_a: assert property (
    $past(!aresetn) |-> out_route_r == '0 && own_r == '0 && !lock_r)
    else $error("pins routed right after reset");

  analog_first_a: assert property (
    analog_en[5] |=> !pin_oe[5] && !pin_out[5] && !remap_own[5])
    else $error("remapped output drove an analog pin");

  default_pin_a: assert property (
    out_route_r[1] == CODE_NC && !analog_en[1] |=> pin_oe[1] == $past(dflt_oe[1])
      && pin_out[1] == $past(dflt_out[1]))
    else $error("default function lost its pin");

  g0_uart_tx_a: assert property (
    out_route_r[0] == G0_UART_A_TX && periph_act.uart_a_transmit && !analog_en[0]
      |=> pin_oe[0] && remap_own[0] && pin_out[0] == $past(periph_out.uart_a_transmit))
    else $error("uart a transmit not on group 0 pin");

  g0_reserved_a: assert property (
    out_route_r[5] == 4'h6 || out_route_r[5] == 4'h8 |=> !remap_own[5])
    else $error("reserved code took a pin");

  g1_compare_a: assert property (
    out_route_r[13] == G1_OC_B && periph_act.compare_out_ch_b && !analog_en[13]
      |=> remap_own[13] && pin_out[13] == $past(periph_out.compare_out_ch_b))
    else $error("compare b not on group 1 pin");

  g2_spi_data_a: assert property (
    out_route_r[21] == G2_SPI_A_SDO && periph_act.spi_a_data_out && !analog_en[21]
      |=> remap_own[21] && pin_out[21] == $past(periph_out.spi_a_data_out))
    else $error("spi a data not on group 2 pin");

  g3_spi_select_a: assert property (
    out_route_r[29] == G3_SPI_B_SS && periph_act.spi_b_slave_select && !analog_en[29]
      |=> remap_own[29] && pin_out[29] == $past(periph_out.spi_b_slave_select))
    else $error("spi b select not on group 3 pin");

  in_route_a: assert property (
    in_route_r[0] == 4'h2 && !analog_en[2] |=> periph_in.uart_a_receive == $past(pin_in[2]))
    else $error("input route picked the wrong pin");

  write_answer_a: assert property (
    do_write && wr_is_in |=> bvalid && $stable(out_route_r))
    else $error("input route write touched output routes");

endmodule

// [tb/prm_remap_tb.sv]
// self-checking bench for the peripheral pin remap block
`timescale 1ns/1ps
module prm_remap_tb
  import prm_pkg::*;
;
  logic                aclk;
  logic                aresetn;
  logic [ADDR_W-1:0]   awaddr;
  logic                awvalid;
  logic                awready;
  logic [DATA_W-1:0]   wdata;
  logic [3:0]          wstrb;
  logic                wvalid;
  logic                wready;
  logic [1:0]          bresp;
  logic                bvalid;
  logic                bready;
  logic [ADDR_W-1:0]   araddr;
  logic                arvalid;
  logic                arready;
  logic [DATA_W-1:0]   rdata;
  logic [1:0]          rresp;
  logic                rvalid;
  logic                rready;
  prm_pout_s           periph_out;
  prm_pout_s           periph_act;
  prm_pin_s            periph_in;
  logic [NUM_PINS-1:0] pin_in;
  logic [NUM_PINS-1:0] analog_en;
  logic [NUM_PINS-1:0] dflt_out;
  logic [NUM_PINS-1:0] dflt_oe;
  logic [NUM_PINS-1:0] pin_out;
  logic [NUM_PINS-1:0] pin_oe;
  logic [NUM_PINS-1:0] remap_own;
  int                  miscompares;
  int                  checks_done;
  logic [1:0]          resp;
  logic [31:0]         rd;

  prm_remap dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .periph_out, .periph_act, .periph_in, .pin_in, .analog_en, .dflt_out,
    .dflt_oe, .pin_out, .pin_oe, .remap_own
  );

  always #5 aclk = ~aclk;

  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // both write channels offered together, each released at the edge that takes it
  // handshakes are judged at the falling edge, where the slave's outputs are settled
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int   n;
    logic aw_go;
    logic w_go;
    logic b_go;
    n = 0;
    b_go = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge aclk);
      n++;
      aw_go = awvalid && awready;
      w_go  = wvalid && wready;
      b_go  = bvalid;
      resp  = bresp;
      @(posedge aclk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
    end while (!b_go && n < 64);
    bready <= 1'b0;
    if (!b_go) miscompares++;
  endtask

  task automatic axi_rd(input logic [11:0] a);
    int   n;
    logic ar_go;
    logic r_go;
    n = 0;
    r_go = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge aclk);
      n++;
      ar_go = arvalid && arready;
      r_go  = rvalid;
      rd    = rdata;
      resp  = rresp;
      @(posedge aclk);
      if (ar_go) arvalid <= 1'b0;
    end while (!r_go && n < 64);
    rready <= 1'b0;
    if (!r_go) miscompares++;
  endtask

  task automatic wr_expect(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    axi_wr(a, d, 4'hf);
    chk(resp, er);
  endtask

  task automatic rd_expect(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    axi_rd(a);
    chk(rd, ed);
    chk(resp, er);
  endtask

  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask

  // bit of prm_pout_s that a group's code routes, -1 for no connect or reserved
  function automatic int sel_bit(input int g, input int c);
    case ({g[1:0], c[3:0]})
      6'h01:   return 9;
      6'h02:   return 8;
      6'h03:   return 7;
      6'h07:   return 6;
      6'h13:   return 5;
      6'h14:   return 4;
      6'h15:   return 3;
      6'h23:   return 5;
      6'h24:   return 4;
      6'h25:   return 1;
      6'h34:   return 0;
      6'h35:   return 2;
      default: return -1;
    endcase
  endfunction

  task automatic t_reset;
    for (int i = 0; i < 42; i++) begin
      rd_expect(12'(4 * i), 32'h0, RESP_OKAY);
    end
    chk(remap_own, 32'h0);
    chk(pin_oe, 32'h0);
    chk(periph_in, 32'h0);
    rd_expect(12'h0fc, 32'h0, RESP_SLVERR);
    wr_expect(12'h0fc, 32'h1, RESP_SLVERR);
  endtask

  task automatic t_out_codes;
    int p;
    int b;
    @(posedge aclk);
    dflt_oe  <= '1;
    dflt_out <= 32'h9c63_36c9;
    for (int g = 0; g < 4; g++) begin
      p = g * 8 + 5;
      for (int c = 0; c < 16; c++) begin
        b = sel_bit(g, c);
        wr_expect(12'(4 * p), 32'(c), RESP_OKAY);
        rd_expect(12'(4 * p), 32'(c), RESP_OKAY);
        @(posedge aclk);
        periph_act <= '1;
        periph_out <= '1;
        analog_en  <= '0;
        settle;
        chk(remap_own[p], b >= 0);
        chk(pin_oe[p], 1'b1);
        chk(pin_out[p], (b >= 0) ? 1'b1 : dflt_out[p]);
        if (b >= 0) begin
          @(posedge aclk);
          periph_out <= prm_pout_s'(~(10'h1 << b));
          settle;
          chk(pin_out[p], 1'b0);
          @(posedge aclk);
          periph_act <= prm_pout_s'(~(10'h1 << b));
          settle;
          chk(remap_own[p], 1'b0);
          chk(pin_out[p], dflt_out[p]);
          @(posedge aclk);
          periph_act <= '1;
          analog_en  <= 32'h1 << p;
          settle;
          chk({pin_oe[p], pin_out[p], remap_own[p]}, 3'b000);
        end
      end
      wr_expect(12'(4 * p), 32'h0, RESP_OKAY);
      @(posedge aclk);
      analog_en <= '0;
      settle;
      chk({pin_oe[p], pin_out[p], remap_own[p]}, {1'b1, dflt_out[p], 1'b0});
    end
  endtask

  task automatic t_inputs;
    int c;
    int p;
    for (int k = 0; k < 8; k++) begin
      c = (k * 3 + 1) % 8;
      p = (k % 4) * 8 + c;
      wr_expect(IN_ROUTE_BASE + 12'(4 * k), 32'(c), RESP_OKAY);
      @(posedge aclk);
      pin_in <= 32'h1 << p;
      settle;
      chk(periph_in[k], 1'b1);
      @(posedge aclk);
      pin_in <= ~(32'h1 << p);
      settle;
      chk(periph_in[k], 1'b0);
    end
    chk(remap_own, 32'h0);
    wr_expect(IN_ROUTE_BASE, 32'h9, RESP_OKAY);
    @(posedge aclk);
    pin_in <= '1;
    settle;
    chk(periph_in[0], 1'b0);
    wr_expect(IN_ROUTE_BASE, 32'h2, RESP_OKAY);
    @(posedge aclk);
    analog_en <= 32'h4;
    settle;
    chk(periph_in[0], 1'b0);
    @(posedge aclk);
    analog_en <= '0;
  endtask

  task automatic t_lock;
    wr_expect(OUT_ROUTE_BASE, 32'h1, RESP_OKAY);
    settle;
    rd_expect(OWN_STAT_ADDR, 32'h1, RESP_OKAY);
    wr_expect(OWN_STAT_ADDR, 32'h0, RESP_SLVERR);
    axi_wr(OUT_ROUTE_BASE, 32'h2, 4'h0);
    chk(resp, RESP_OKAY);
    rd_expect(OUT_ROUTE_BASE, 32'h1, RESP_OKAY);
    wr_expect(LOCK_ADDR, 32'h1, RESP_OKAY);
    rd_expect(LOCK_ADDR, 32'h1, RESP_OKAY);
    wr_expect(OUT_ROUTE_BASE, 32'h3, RESP_SLVERR);
    wr_expect(IN_ROUTE_BASE, 32'h5, RESP_SLVERR);
    rd_expect(OUT_ROUTE_BASE, 32'h1, RESP_OKAY);
    rd_expect(IN_ROUTE_BASE, 32'h2, RESP_OKAY);
    axi_wr(LOCK_ADDR, 32'h1234_0000, 4'hf);
    rd_expect(LOCK_ADDR, 32'h1, RESP_OKAY);
    wr_expect(LOCK_ADDR, {UNLOCK_KEY, 16'h0}, RESP_OKAY);
    rd_expect(LOCK_ADDR, 32'h0, RESP_OKAY);
    wr_expect(OUT_ROUTE_BASE, 32'h0, RESP_OKAY);
    rd_expect(OUT_ROUTE_BASE, 32'h0, RESP_OKAY);
  endtask

  // a hang past the expected run length ends the run as a failure
  initial begin
    #200_000;
    miscompares++;
    report_and_stop;
  end

  initial begin
    aclk        = 1'b0;
    aresetn     = 1'b0;
    awaddr      = '0;
    awvalid     = 1'b0;
    wdata       = '0;
    wstrb       = '0;
    wvalid      = 1'b0;
    bready      = 1'b0;
    araddr      = '0;
    arvalid     = 1'b0;
    rready      = 1'b0;
    periph_out  = '0;
    periph_act  = '0;
    pin_in      = '0;
    analog_en   = '0;
    dflt_out    = '0;
    dflt_oe     = '0;
    miscompares = 0;
    checks_done = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_out_codes;
    t_inputs;
    t_lock;
    report_and_stop;
  end
endmodule
